// *** src/sltpg_top.sv ***
// Training pattern sequencer with normal-data pass-through and output buffer
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module sltpg_top #(
  parameter int FRAME_BYTES = 0,
  parameter int BUF_DEPTH = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Training control
  input wire logic train_en,
  input wire logic [sltpg_pkg::WORD_W-1:0] frame_data,
  output logic training_active,
  // Normal traffic in
  input wire logic user_valid,
  input wire logic [sltpg_pkg::WORD_W-1:0] user_data,
  output logic user_ready,
  // Words to the serializer
  output logic tx_valid,
  output logic [sltpg_pkg::WORD_W-1:0] tx_data,
  output logic tx_train,
  output logic tx_rep_start,
  input wire logic tx_ready
);

  localparam int IW = 6;
  localparam int WORD_W = sltpg_pkg::WORD_W;
  // fixed part then random part fill one repetition
  localparam logic [IW-1:0] LAST_FIXED = IW'(sltpg_pkg::FIXED_BYTES - 1);
  localparam logic [IW-1:0] LAST_RAND = IW'(sltpg_pkg::REP_BYTES - 1);
  localparam logic [IW-1:0] RAND_START = IW'(sltpg_pkg::FIXED_BYTES);
  localparam logic [IW-1:0] LAST_FRAME = IW'(FRAME_BYTES - 1);

  // Geometry the sequencer cannot serve, refused at elaboration
  if (FRAME_BYTES < 0 || FRAME_BYTES > 63 || sltpg_pkg::REP_BYTES > 63) begin : g_frame
    $error("sltpg_top: FRAME_BYTES must be 0 to 63");
  end
  if (sltpg_pkg::REP_BITS % WORD_W != 0 || sltpg_pkg::RAND_BITS % WORD_W != 0) begin : g_rep
    $error("sltpg_top: repetition not a whole number of words");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset release

  logic [1:0] rst_sync_reg;
  wire rst_n = rst_sync_reg[1];

  // Assert at once, release after two edges
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sources

  logic [WORD_W-1:0] rnd_word;

  sltpg_lfsr #(
    .LEN(sltpg_pkg::LFSR_W),
    .TAP(sltpg_pkg::LFSR_TAP),
    .OUT_W(WORD_W),
    .SEED(sltpg_pkg::LFSR_SEED)
  ) u_lfsr (
    .clk(clk),
    .rst_n(rst_n),
    .rnd(rnd_word)
  );

  sltpg_pkg::sltpg_state_e state_reg;
  sltpg_pkg::sltpg_state_e state_next;
  logic [IW-1:0] idx_reg;
  logic [IW-1:0] idx_next;
  logic user_ready_reg;
  logic active_reg;

  // fixed pattern byte for the current position
  wire [8:0] fix_bit = 9'(sltpg_pkg::FIXED_BITS - 1) - {idx_reg, 3'h0};
  wire [WORD_W-1:0] fixed_word = sltpg_pkg::FIXED_PATTERN[fix_bit -: WORD_W];

  ////////////////////////////////////////////////////////////////////////////
  // Buffer feed

  logic buf_in_ready;
  logic buf_space_next;
  logic buf_out_valid;
  sltpg_pkg::sltpg_word_s buf_out;
  sltpg_pkg::sltpg_word_s src_word;

  wire in_normal = state_reg == sltpg_pkg::ST_NORMAL;
  wire in_fixed = state_reg == sltpg_pkg::ST_FIXED;
  wire in_rand = state_reg == sltpg_pkg::ST_RAND;
  wire in_frame = state_reg == sltpg_pkg::ST_FRAME;
  wire user_push = in_normal && user_valid && user_ready_reg;
  wire gen_push = !in_normal && buf_in_ready;
  wire push = user_push || gen_push;

  // Word selection by state
  wire [WORD_W-1:0] gen_data = in_fixed ? fixed_word : in_rand ? rnd_word : frame_data;
  assign src_word.data = in_normal ? user_data : gen_data;
  assign src_word.train = !in_normal;
  assign src_word.rep_start = in_fixed && idx_reg == '0;

  sltpg_buf #(
    .DATA_W($bits(sltpg_pkg::sltpg_word_s)),
    .DEPTH(BUF_DEPTH)
  ) u_buf (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(push),
    .in_data(src_word),
    .in_ready(buf_in_ready),
    .space_next(buf_space_next),
    .out_valid(buf_out_valid),
    .out_data(buf_out),
    .out_ready(tx_ready)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  wire last_fixed = in_fixed && idx_reg == LAST_FIXED;
  wire last_rand = in_rand && idx_reg == LAST_RAND;
  wire last_frame = in_frame && idx_reg == LAST_FRAME;
  wire rep_end = gen_push && (FRAME_BYTES == 0 ? last_rand : last_frame);

  // Next state and position
  always_comb begin
    state_next = state_reg;
    idx_next = idx_reg;
    unique case (state_reg)
      sltpg_pkg::ST_NORMAL: begin
        if (train_en) begin
          state_next = sltpg_pkg::ST_FIXED;
          idx_next = '0;
        end
      end
      sltpg_pkg::ST_FIXED: begin
        if (gen_push) begin
          idx_next = idx_reg + IW'(1);
          if (last_fixed) begin
            state_next = sltpg_pkg::ST_RAND;
          end
        end
      end
      // random words after the fixed part
      sltpg_pkg::ST_RAND: begin
        if (gen_push && last_rand) begin
          idx_next = '0;
          if (FRAME_BYTES != 0) begin
            state_next = sltpg_pkg::ST_FRAME;
          end else begin
            state_next = train_en ? sltpg_pkg::ST_FIXED : sltpg_pkg::ST_NORMAL;
          end
        end else if (gen_push) begin
          idx_next = idx_reg + IW'(1);
        end
      end
      sltpg_pkg::ST_FRAME: begin
        if (gen_push && last_frame) begin
          idx_next = '0;
          state_next = train_en ? sltpg_pkg::ST_FIXED : sltpg_pkg::ST_NORMAL;
        end else if (gen_push) begin
          idx_next = idx_reg + IW'(1);
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= sltpg_pkg::ST_NORMAL;
      idx_reg <= '0;
    end else begin
      state_reg <= state_next;
      idx_reg <= idx_next;
    end
  end

  // Registered user ready and activity flag
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      user_ready_reg <= 1'b0;
      active_reg <= 1'b0;
    end else begin
      user_ready_reg <= state_next == sltpg_pkg::ST_NORMAL && buf_space_next;
      active_reg <= state_next != sltpg_pkg::ST_NORMAL;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign user_ready = user_ready_reg;
  assign training_active = active_reg;
  assign tx_valid = buf_out_valid;
  assign tx_data = buf_out.data;
  assign tx_train = buf_out.train;
  assign tx_rep_start = buf_out.rep_start;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  a_low_square_open: assert property (@(posedge clk) disable iff (!rst_n)
    gen_push && in_fixed && idx_reg == 6'h00 ##1 gen_push && in_fixed |->
      $past(src_word.data) == 8'h00 && src_word.data == 8'hff)
    else $error("opening square wave wrong");

  a_open_square_span: assert property (@(posedge clk) disable iff (!rst_n)
    gen_push && in_fixed && idx_reg <= 6'h05 |->
      src_word.data == (idx_reg[0] ? 8'hff : 8'h00))
    else $error("opening square wave byte wrong");

  a_low_square_fifth: assert property (@(posedge clk) disable iff (!rst_n)
    gen_push && in_fixed && idx_reg == 6'h12 |-> src_word.data == 8'h00)
    else $error("fifth segment wrong");

  a_fifth_square_span: assert property (@(posedge clk) disable iff (!rst_n)
    gen_push && in_fixed && idx_reg >= 6'h12 && idx_reg <= 6'h17 |->
      src_word.data == (idx_reg[0] ? 8'hff : 8'h00))
    else $error("fifth segment byte wrong");

  a_pos_impulse: assert property (@(posedge clk) disable iff (!rst_n)
    gen_push && in_fixed && idx_reg >= 6'h06 && idx_reg <= 6'h08 |->
      src_word.data == (idx_reg == 6'h07 ? 8'h80 : 8'h00))
    else $error("positive impulse wrong");

  a_half_rate_sq: assert property (@(posedge clk) disable iff (!rst_n)
    gen_push && in_fixed && idx_reg >= 6'h09 && idx_reg <= 6'h0e |->
      src_word.data == 8'h55)
    else $error("half rate square wave wrong");

  a_neg_impulse: assert property (@(posedge clk) disable iff (!rst_n)
    gen_push && in_fixed && idx_reg >= 6'h0f && idx_reg <= 6'h11 |->
      src_word.data == (idx_reg == 6'h10 ? 8'hef : 8'hff))
    else $error("negative impulse wrong");

  a_rand_span: assert property (@(posedge clk) disable iff (!rst_n)
    in_rand |-> idx_reg >= RAND_START && idx_reg <= LAST_RAND)
    else $error("random segment out of span");

  // random segment ends after its last word
  a_rand_exit: assert property (@(posedge clk) disable iff (!rst_n)
    gen_push && last_rand |=> !in_rand)
    else $error("random segment overran");

  a_rep_length: assert property (@(posedge clk) disable iff (!rst_n)
    gen_push && last_fixed |=> in_rand && idx_reg == 6'h18)
    else $error("repetition shorter than 384 bits");

  a_repeat_loop: assert property (@(posedge clk) disable iff (!rst_n)
    rep_end && train_en |=> in_fixed && idx_reg == '0)
    else $error("repetition did not restart");

  a_frame_count: assert property (@(posedge clk) disable iff (!rst_n)
    in_frame |-> FRAME_BYTES != 0 && idx_reg <= LAST_FRAME)
    else $error("framing count wrong");

  a_frame_word: assert property (@(posedge clk) disable iff (!rst_n)
    gen_push && in_frame |-> src_word.data == frame_data && src_word.train)
    else $error("framing word wrong");

  a_start_first: assert property (@(posedge clk) disable iff (!rst_n)
    in_normal && train_en |=> in_fixed && idx_reg == '0 && training_active)
    else $error("start not at first segment");

  a_stop_boundary: assert property (@(posedge clk) disable iff (!rst_n)
    !in_normal ##1 in_normal |-> $past(rep_end) && !$past(train_en))
    else $error("stopped inside a repetition");

  a_user_blocked: assert property (@(posedge clk) disable iff (!rst_n)
    training_active |-> !user_ready)
    else $error("user path open during training");

endmodule

// *** src/sltpg_pkg.sv ***
// Shared constants, types and pattern content of the lane training pattern generator
package sltpg_pkg;

  // Word and repetition geometry
  localparam int WORD_W = 8;
  localparam int REP_BITS = 384;
  localparam int RAND_BITS = 192;
  localparam int FIXED_BITS = REP_BITS - RAND_BITS;
  localparam int FIXED_BYTES = FIXED_BITS / WORD_W;
  localparam int REP_BYTES = REP_BITS / WORD_W;

  // Segment lengths in bits
  localparam int SEG_LOW_SQ_BITS = 48;
  localparam int SEG_IMPULSE_BITS = 24;
  localparam int SEG_HIGH_SQ_BITS = 48;

  // Fixed segments in transmit order, first byte in the top bits
  localparam logic [FIXED_BITS-1:0] FIXED_PATTERN = {
    48'h00ff00ff00ff,
    24'h008000,
    48'h555555555555,
    24'hffefff,
    48'h00ff00ff00ff
  };

  // Pseudo-random source: x^31 + x^28 + 1
  localparam int LFSR_W = 31;
  localparam int LFSR_TAP = 28;
  localparam logic [LFSR_W-1:0] LFSR_SEED = 31'h2a5a_c3e1;

  // Sequencer states, Gray along normal -> fixed -> random -> framing
  typedef enum logic [1:0] {
    ST_NORMAL = 2'b00,
    ST_FIXED = 2'b01,
    ST_RAND = 2'b11,
    ST_FRAME = 2'b10
  } sltpg_state_e;

  // One transmit word with its markers
  typedef struct packed {
    logic [WORD_W-1:0] data;
    logic train;
    logic rep_start;
  } sltpg_word_s;

endpackage

// *** src/sltpg_lfsr.sv ***
// Free-running Fibonacci LFSR giving several fresh bits per clock
`timescale 1ns/1ps
module sltpg_lfsr #(
  parameter int LEN = sltpg_pkg::LFSR_W,
  parameter int TAP = sltpg_pkg::LFSR_TAP,
  parameter int OUT_W = sltpg_pkg::WORD_W,
  parameter logic [sltpg_pkg::LFSR_W-1:0] SEED = sltpg_pkg::LFSR_SEED
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Random word
  output logic [OUT_W-1:0] rnd
);

  logic [LEN-1:0] state_reg;
  logic [LEN-1:0] state_next;
  logic [OUT_W-1:0] bits;

  // Parameters the shift network cannot serve, refused at elaboration
  if (LEN != sltpg_pkg::LFSR_W || TAP >= LEN || TAP < 1 ||
      OUT_W > LEN || SEED == '0) begin : g_bad
    $error("sltpg_lfsr: unsupported parameters");
  end

  // Step the register OUT_W times per clock
  always_comb begin
    logic [LEN-1:0] s;
    s = state_reg;
    bits = '0;
    for (int i = 0; i < OUT_W; i++) begin
      bits[OUT_W-1-i] = s[LEN-1] ^ s[TAP-1];
      s = {s[LEN-2:0], bits[OUT_W-1-i]};
    end
    state_next = s;
  end

  // Nonzero seed loaded at reset, then runs every clock
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= SEED;
    end else begin
      state_reg <= state_next;
    end
  end

  assign rnd = bits;

  a_lfsr_nonzero: assert property (@(posedge clk) disable iff (!rst_n)
    state_reg != '0) else $error("lfsr reached all zeros");

endmodule

// *** src/sltpg_buf.sv ***
// Small shift FIFO with registered ready, valid and head word
`timescale 1ns/1ps
module sltpg_buf #(
  parameter int DATA_W = 10,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Fill side
  input wire logic in_valid,
  input wire logic [DATA_W-1:0] in_data,
  output logic in_ready,
  output logic space_next,
  // Drain side
  output logic out_valid,
  output logic [DATA_W-1:0] out_data,
  input wire logic out_ready
);

  localparam int CW = $clog2(DEPTH + 1);

  logic [DATA_W-1:0] mem [DEPTH];
  logic [CW-1:0] count_reg;
  logic [CW-1:0] count_next;
  logic in_ready_reg;
  logic out_valid_reg;

  // Sizes the shift network cannot serve, refused at elaboration
  if (DEPTH < 2 || DATA_W < 1) begin : g_bad
    $error("sltpg_buf: DEPTH must be at least 2");
  end

  // Handshakes and occupancy
  wire push = in_valid && in_ready_reg;
  wire pop = out_valid_reg && out_ready;
  wire [CW-1:0] wr_pos = pop ? count_reg - CW'(1) : count_reg;
  assign count_next = count_reg + CW'(push) - CW'(pop);
  assign space_next = count_next < CW'(DEPTH);

  // Occupancy and registered flags
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= '0;
      in_ready_reg <= 1'b0;
      out_valid_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      in_ready_reg <= space_next;
      out_valid_reg <= count_next != '0;
    end
  end

  // Entries shift toward the head on every pop
  for (genvar i = 0; i < DEPTH; i++) begin : g_ent
    logic [DATA_W-1:0] shifted;
    if (i < DEPTH - 1) begin : g_mid
      assign shifted = pop ? mem[i+1] : mem[i];
    end else begin : g_last
      assign shifted = mem[i];
    end
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        mem[i] <= '0;
      end else if (push && wr_pos == CW'(i)) begin
        mem[i] <= in_data;
      end else begin
        mem[i] <= shifted;
      end
    end
  end

  assign in_ready = in_ready_reg;
  assign out_valid = out_valid_reg;
  assign out_data = mem[0];

  // A stalled head word holds until taken
  a_head_stable: assert property (@(posedge clk) disable iff (!rst_n)
    out_valid_reg && !out_ready |=> out_valid_reg && $stable(mem[0]))
    else $error("head word changed while stalled");

endmodule

// *** verification/sltpg_rx_model.sv ***
// Serializer-side model that takes transmit words at a chosen pace and logs them
`timescale 1ns/1ps
module sltpg_rx_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Pacing: low takes every word, high takes one word in three
  input wire logic slow,
  // Words from the generator
  input wire logic tx_valid,
  input wire sltpg_pkg::sltpg_word_s word,
  output logic tx_ready
);
  sltpg_pkg::sltpg_word_s log_q[$];
  logic [1:0] pace_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Pacing counter, stepped just after each edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pace_reg <= 2'h0;
    end else begin
      pace_reg <= (pace_reg == 2'h2) ? 2'h0 : pace_reg + 2'h1;
    end
  end

  // Ready follows the pace only, never the offered word
  assign tx_ready = rst_n && (!slow || pace_reg == 2'h0);

  ////////////////////////////////////////////////////////////////////////////////
  // framing tolerated
  // Every accepted word is logged, framing bytes included
  always @(posedge clk) begin
    if (rst_n && tx_valid && tx_ready) begin
      log_q.push_back(word);
    end
  end
endmodule

// *** verification/testbench.sv ***
// Self-checking bench for the lane training pattern generator
`timescale 1ns/1ps
module testbench;
  localparam int FRAME_N = 2;
  localparam int REP_N = 48 + FRAME_N;
  localparam logic [191:0] FIXED_EXP = {48'h00ff00ff00ff, 24'h008000, 48'h555555555555,
    24'hffefff, 48'h00ff00ff00ff};
  localparam logic [7:0] FRAME_BYTE = 8'h5a;
  logic clk;
  logic resetn;
  logic train_en;
  logic user_valid;
  logic slow;
  logic training_active;
  logic user_ready;
  logic tx_valid;
  logic tx_train;
  logic tx_rep_start;
  logic tx_ready;
  logic [7:0] frame_data;
  logic [7:0] user_data;
  logic [7:0] tx_data;
  sltpg_pkg::sltpg_word_s tx_word;
  int n_mismatch;
  int samples_checked;
  int refused;

  assign tx_word = {tx_data, tx_train, tx_rep_start};

  sltpg_top #(.FRAME_BYTES(FRAME_N), .BUF_DEPTH(2)) dut (
    .clk(clk), .resetn(resetn), .train_en(train_en), .frame_data(frame_data),
    .training_active(training_active), .user_valid(user_valid), .user_data(user_data),
    .user_ready(user_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_train(tx_train),
    .tx_rep_start(tx_rep_start), .tx_ready(tx_ready)
  );

  sltpg_rx_model rx (
    .clk(clk), .rst_n(resetn), .slow(slow), .tx_valid(tx_valid), .word(tx_word),
    .tx_ready(tx_ready)
  );

  // Clock at 40 MHz
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Shared compare, verdict and wait tasks
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic results();
    $display("Checks %0d, mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Wait for the log to reach n words, bounded
  task automatic wait_log(input int n);
    int k;
    k = 0;
    while (rx.log_q.size() < n && k < 3000) begin
      @(posedge clk);
      k++;
    end
    if (rx.log_q.size() < n) begin
      check("log count", rx.log_q.size(), n);
      results();
    end
  endtask

  // Offer one user word and hold it until the edge that takes it
  task automatic send_user(input logic [7:0] d);
    int k;
    k = 0;
    user_valid <= 1'b1;
    user_data <= d;
    @(posedge clk);
    while (!user_ready && k < 500) begin
      refused++;
      @(posedge clk);
      k++;
    end
    if (!user_ready) begin
      check("user take", user_ready, 1'b1);
      results();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Scenario: outputs quiet in reset, normal path opens after release
  task automatic sc_reset();
    int k;
    k = 0;
    check("tx_valid in reset", tx_valid, 1'b0);
    check("training_active in reset", training_active, 1'b0);
    resetn <= 1'b1;
    @(posedge clk);
    while (!user_ready && k < 6) begin
      @(posedge clk);
      k++;
    end
    check("user_ready after reset", user_ready, 1'b1);
  endtask

  // Scenario: back-to-back user words under a stalling receiver
  task automatic sc_user();
    slow <= 1'b1;
    refused = 0;
    for (int i = 0; i < 6; i++) begin
      send_user(8'h10 + 8'(i));
    end
    user_valid <= 1'b0;
    wait_log(6);
    check("buffer refused", refused > 0, 1'b1);
    for (int i = 0; i < 6; i++) begin
      check("user data", rx.log_q[i].data, 8'h10 + 8'(i));
      check("user train", rx.log_q[i].train, 1'b0);
    end
    rx.log_q.delete();
  endtask

  // Scenario: two full repetitions, stop mid third, normal data resumes
  task automatic sc_train_stop();
    int diff;
    int nz;
    sltpg_pkg::sltpg_word_s w;
    diff = 0;
    nz = 0;
    train_en <= 1'b1;
    wait_log(2 * REP_N);
    check("training_active", training_active, 1'b1);
    for (int r = 0; r < 2; r++) begin
      for (int i = 0; i < REP_N; i++) begin
        w = rx.log_q[r * REP_N + i];
        check("pattern train", w.train, 1'b1);
        check("repetition start", w.rep_start, i == 0);
        if (i < 24) begin
          check("fixed byte", w.data, FIXED_EXP[191 - 8 * i -: 8]);
        end else if (i >= 48) begin
          check("framing byte", w.data, FRAME_BYTE);
        end else if (r == 0) begin
          diff += (w.data != rx.log_q[REP_N + i].data);
          nz += (w.data != 8'h00);
        end
      end
    end
    check("random nonzero", nz > 0, 1'b1);
    check("random differs", diff > 0, 1'b1);
    // Drop the request in mid repetition
    wait_log(2 * REP_N + 10);
    train_en <= 1'b0;
    for (int k = 0; k < 400 && training_active; k++) begin
      @(posedge clk);
    end
    check("training stopped", training_active, 1'b0);
    if (training_active) begin
      results();
    end
    send_user(8'hc3);
    user_valid <= 1'b0;
    wait_log(3 * REP_N + 1);
    repeat (10) @(posedge clk);
    check("words after stop", rx.log_q.size(), 3 * REP_N + 1);
    check("third start", rx.log_q[2 * REP_N].rep_start, 1'b1);
    check("last framing", rx.log_q[3 * REP_N - 1].data, FRAME_BYTE);
    check("user after stop", rx.log_q[3 * REP_N].data, 8'hc3);
    check("user not train", rx.log_q[3 * REP_N].train, 1'b0);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    n_mismatch = 0;
    samples_checked = 0;
    refused = 0;
    resetn = 1'b0;
    train_en = 1'b0;
    user_valid = 1'b0;
    user_data = 8'h00;
    frame_data = FRAME_BYTE;
    slow = 1'b0;
    repeat (8) @(posedge clk);
    sc_reset();
    sc_user();
    sc_train_stop();
    results();
  end
endmodule
